// >>> hdl/rx_status_pkg.sv
/*
  constants for the receive status word builder: rates, mode codes, field
  positions, carrier thresholds and reset values.
  assumes a single 25 MHz machine clock.
*/
package rx_status_pkg;
  // timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DATA_EXCH_HZ = 600;
  localparam int unsigned FSK_EXCH_HZ = 1200;
  localparam int unsigned DATA_EXCH_CYC = CLK_HZ / DATA_EXCH_HZ;
  localparam int unsigned FSK_EXCH_CYC = CLK_HZ / FSK_EXCH_HZ;
  localparam int CNT_W = 16;
  // receive mode codes (command first byte bits 3:0)
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_QAM = 4'h1;
  localparam logic [3:0] MODE_DPSK = 4'h2;
  localparam logic [3:0] MODE_FSK_FIRST = 4'h3;
  localparam logic [3:0] MODE_FSK_LAST = 4'h6;
  localparam logic [3:0] MODE_TONE = 4'h7;
  // word layout
  localparam int BYTE_W = 8;
  localparam int WORD_W = 24;
  localparam int DATA_W = 4;
  localparam int SAMPLES = 6;
  localparam int SAMP_CNT_W = 3;
  localparam logic [2:0] SAMP_LAST = 3'h5;
  localparam int FB_RECEIVE = 0;
  localparam int FB_DATA_LSB = 1;
  localparam int FB_RSV = 5;
  localparam int FB_S1_LSB = 6;
  localparam int FB_CP = 7;
  localparam int SB_EQ = 4;
  localparam int SB_QUAL = 5;
  localparam int SB_CD = 6;
  localparam int TB_DATA_LSB = 1;
  localparam int TB_TONE = 7;
  localparam logic [7:0] BYTE_RSV = 8'h00;
  localparam logic [3:0] DATA_UNUSED = 4'hf;
  localparam logic [5:0] SAMP_IDLE = 6'h3f;
  localparam logic [3:0] MASK_QAM = 4'hf;
  localparam logic [3:0] MASK_DPSK_HI = 4'h3;
  localparam logic [3:0] MASK_DPSK_LO = 4'h1;
  localparam logic [1:0] S1_PHASE_A = 2'h2;
  localparam logic [1:0] S1_PHASE_B = 2'h1;
  localparam logic [1:0] S1_NONE = 2'h0;
  // carrier thresholds in signed dBm
  localparam logic signed [7:0] CD_ON_PSTN = 8'shd5;
  localparam logic signed [7:0] CD_OFF_PSTN = 8'shd0;
  localparam logic signed [7:0] CD_ON_LEASED = 8'shdf;
  localparam logic signed [7:0] CD_OFF_LEASED = 8'shda;
  localparam logic signed [7:0] CD_HYST_MIN = 8'sh02;
  localparam logic CD_LOST_RST = 1'b1;
endpackage

// >>> hdl/mailbox_word_if.sv
/*
  valid/ready carrier for one status word between the builder and the buffer.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface mailbox_word_if #(parameter int W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/exch_tick.sv
/*
  periodic one-cycle tick while run is high; restarts when run drops.
  assumes clock enable gates every state change.
*/
`timescale 1ns/1ps
module exch_tick #(
  parameter int unsigned PERIOD = 16
) (
  // clock and control
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic run_in,
  // tick
  output logic tick_out
);
  import rx_status_pkg::*;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic tick_ff, nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff + 16'h0001;
    nxt_tick = 1'b0;
    if (!run_in) begin
      nxt_cnt = 16'h0000;
    end else if (cnt_ff == LAST) begin
      nxt_cnt = 16'h0000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (ce_in) begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;
endmodule

// >>> hdl/status_skid.sv
/*
  two-entry buffer between the word builder and the mailbox reader.
  assumes the reader may hold ready low for any time; writer sees ready drop
  once both entries are full.
*/
`timescale 1ns/1ps
module status_skid #(
  parameter int W = 24
) (
  // clock and control
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // fill side
  mailbox_word_if.snk push,
  // drain side
  input wire logic ready_in,
  output logic valid_out,
  output logic [W-1:0] data_out
);
  logic out_valid_ff, skid_valid_ff, nxt_out_valid, nxt_skid_valid;
  logic [W-1:0] out_ff, skid_ff, nxt_out, nxt_skid;
  logic accept, drain;

  assign push.ready = !skid_valid_ff;
  assign accept = ce_in && push.valid && !skid_valid_ff;
  assign drain = ce_in && out_valid_ff && ready_in;

  always_comb begin
    nxt_out = out_ff;
    nxt_skid = skid_ff;
    nxt_out_valid = out_valid_ff;
    nxt_skid_valid = skid_valid_ff;
    // the second entry moves up on a take, otherwise it would block the fill side forever
    if (drain) begin
      nxt_out_valid = skid_valid_ff;
      nxt_skid_valid = 1'b0;
      if (skid_valid_ff) begin
        nxt_out = skid_ff;
      end
    end
    if (accept) begin
      if (!nxt_out_valid) begin
        nxt_out = push.data;
        nxt_out_valid = 1'b1;
      end else begin
        nxt_skid = push.data;
        nxt_skid_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      out_valid_ff <= 1'b0;
      skid_valid_ff <= 1'b0;
      out_ff <= '0;
      skid_ff <= '0;
    end else if (ce_in) begin
      out_valid_ff <= nxt_out_valid;
      skid_valid_ff <= nxt_skid_valid;
      out_ff <= nxt_out;
      skid_ff <= nxt_skid;
    end
  end

  assign valid_out = out_valid_ff;
  assign data_out = out_ff;

  cov_buffer_full: cover property (@(posedge clock_in) disable iff (rst_in) skid_valid_ff && out_valid_ff);
endmodule

// >>> hdl/rx_status_word.sv
/*
  builds the three-byte receive status word from demodulator and detector
  flags and posts it to the mailbox at the mode's exchange rate.
  assumes all inputs are synchronous to clock_in; command fields are held
  stable by the datapump between writes.
*/
// Functional notes
// - s1 present alternates bits 7:6 each baud
// - call progress energy drives first bit7 low
// - equalization loss sets second byte bit4
// - poor signal quality sets second byte bit5
// - carrier detect low above, high below thresholds
// - carrier detect keeps at least 2 dB hysteresis
// - third data is descrambled only when enabled
// - data width by mode, unused bits one
// - data modes exchange 600 words per second
// - fsk word carries six samples, 1200 per second
// - answer tone present drives third bit7 low
// - first byte bit0 always one for receive
`timescale 1ns/1ps
module rx_status_word #(
  parameter int unsigned DATA_EXCH_CYCLES = rx_status_pkg::DATA_EXCH_CYC,
  parameter int unsigned FSK_EXCH_CYCLES = rx_status_pkg::FSK_EXCH_CYC
) (
  // clock and control
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // receive command fields
  input wire logic [rx_status_pkg::MODE_W-1:0] mode_in,
  input wire logic tone_1650_sel_in,
  input wire logic leased_line_in,
  input wire logic descrambler_en_in,
  input wire logic low_rate_in,
  // demodulated data
  input wire logic baud_strobe_in,
  input wire logic [rx_status_pkg::DATA_W-1:0] raw_bits_in,
  input wire logic [rx_status_pkg::DATA_W-1:0] descr_bits_in,
  input wire logic s1_present_in,
  input wire logic sample_strobe_in,
  input wire logic sample_in,
  // detectors
  input wire logic cp_energy_in,
  input wire logic tone_2100_in,
  input wire logic tone_1650_in,
  input wire logic retrain_in,
  input wire logic fallback_in,
  input wire logic quality_low_in,
  input wire logic signed [7:0] line_level_in,
  // mailbox
  input wire logic mailbox_ready_in,
  output logic status_valid_out,
  output logic [rx_status_pkg::BYTE_W-1:0] status_first_out,
  output logic [rx_status_pkg::BYTE_W-1:0] status_second_out,
  output logic [rx_status_pkg::BYTE_W-1:0] status_third_out
);
  import rx_status_pkg::*;

  logic is_qam, is_dpsk, is_fsk, is_tone, is_data, run_slow;
  logic tick_slow, tick_fsk, exch_tick;
  logic [DATA_W-1:0] used_mask;

  assign is_qam = (mode_in == MODE_QAM);
  assign is_dpsk = (mode_in == MODE_DPSK);
  assign is_fsk = (mode_in >= MODE_FSK_FIRST) && (mode_in <= MODE_FSK_LAST);
  assign is_tone = (mode_in == MODE_TONE);
  assign is_data = is_qam || is_dpsk;
  // disabled modem posts nothing; tone mode shares the slow rate
  assign run_slow = is_data || is_tone;

  always_comb begin
    if (is_qam) begin
      used_mask = MASK_QAM;
    end else if (low_rate_in) begin
      used_mask = MASK_DPSK_LO;
    end else begin
      used_mask = MASK_DPSK_HI;
    end
  end

  exch_tick #(.PERIOD(DATA_EXCH_CYCLES)) u_tick_slow (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(run_slow),
    .tick_out(tick_slow)
  );

  exch_tick #(.PERIOD(FSK_EXCH_CYCLES)) u_tick_fsk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(is_fsk),
    .tick_out(tick_fsk)
  );

  assign exch_tick = ce_in && ((run_slow && tick_slow) || (is_fsk && tick_fsk));

  // baud data and s1 phase
  logic s1_phase_ff, nxt_s1_phase;
  logic [DATA_W-1:0] raw_ff, nxt_raw, rx_ff, nxt_rx;

  always_comb begin
    nxt_s1_phase = s1_phase_ff;
    nxt_raw = raw_ff;
    nxt_rx = rx_ff;
    if (!s1_present_in) begin
      nxt_s1_phase = 1'b0;
    end else if (baud_strobe_in) begin
      nxt_s1_phase = !s1_phase_ff;
    end
    if (baud_strobe_in) begin
      nxt_raw = raw_bits_in;
      nxt_rx = descrambler_en_in ? descr_bits_in : raw_bits_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s1_phase_ff <= 1'b0;
      raw_ff <= DATA_UNUSED;
      rx_ff <= DATA_UNUSED;
    end else if (ce_in) begin
      s1_phase_ff <= nxt_s1_phase;
      raw_ff <= nxt_raw;
      rx_ff <= nxt_rx;
    end
  end

  // fsk sample gathering: newest enters at the top so the earliest lands at bit 1
  logic [SAMPLES-1:0] samp_sr_ff, nxt_samp_sr, group_ff, nxt_group;
  logic [SAMP_CNT_W-1:0] samp_cnt_ff, nxt_samp_cnt;

  always_comb begin
    nxt_samp_sr = samp_sr_ff;
    nxt_group = group_ff;
    nxt_samp_cnt = samp_cnt_ff;
    if (!is_fsk) begin
      nxt_samp_cnt = 3'h0;
    end else if (sample_strobe_in) begin
      nxt_samp_sr = {sample_in, samp_sr_ff[SAMPLES-1:1]};
      if (samp_cnt_ff == SAMP_LAST) begin
        nxt_group = nxt_samp_sr;
        nxt_samp_cnt = 3'h0;
      end else begin
        nxt_samp_cnt = samp_cnt_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      samp_sr_ff <= SAMP_IDLE;
      group_ff <= SAMP_IDLE;
      samp_cnt_ff <= 3'h0;
    end else if (ce_in) begin
      samp_sr_ff <= nxt_samp_sr;
      group_ff <= nxt_group;
      samp_cnt_ff <= nxt_samp_cnt;
    end
  end

  // carrier detect; the band between thresholds holds the last state
  logic cd_lost_ff, nxt_cd_lost;
  logic signed [7:0] cd_on_th, cd_off_th;

  assign cd_on_th = leased_line_in ? CD_ON_LEASED : CD_ON_PSTN;
  assign cd_off_th = leased_line_in ? CD_OFF_LEASED : CD_OFF_PSTN;

  always_comb begin
    nxt_cd_lost = cd_lost_ff;
    if (line_level_in > cd_on_th) begin
      nxt_cd_lost = 1'b0;
    end else if (line_level_in < cd_off_th) begin
      nxt_cd_lost = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cd_lost_ff <= CD_LOST_RST;
    end else if (ce_in) begin
      cd_lost_ff <= nxt_cd_lost;
    end
  end

  // word assembly
  logic [BYTE_W-1:0] fb, sb, tb;

  always_comb begin
    fb = BYTE_RSV;
    sb = BYTE_RSV;
    tb = BYTE_RSV;
    fb[FB_RECEIVE] = 1'b1;
    fb[FB_DATA_LSB +: DATA_W] = DATA_UNUSED;
    tb[TB_DATA_LSB +: SAMPLES] = SAMP_IDLE;
    tb[TB_TONE] = 1'b1;
    sb[SB_EQ] = retrain_in || fallback_in;
    sb[SB_QUAL] = quality_low_in;
    sb[SB_CD] = cd_lost_ff;
    if (is_data) begin
      fb[FB_DATA_LSB +: DATA_W] = raw_ff | ~used_mask;
      tb[TB_DATA_LSB +: DATA_W] = rx_ff | ~used_mask;
      if (s1_present_in) begin
        fb[FB_S1_LSB +: 2] = s1_phase_ff ? S1_PHASE_A : S1_PHASE_B;
      end else begin
        fb[FB_S1_LSB +: 2] = S1_NONE;
      end
    end else if (is_fsk) begin
      tb[TB_DATA_LSB +: SAMPLES] = group_ff;
    end else if (is_tone) begin
      fb[FB_CP] = !cp_energy_in;
      tb[TB_TONE] = !(tone_1650_sel_in ? tone_1650_in : tone_2100_in);
    end
  end

  // pending word; a fresher word replaces one the buffer has not yet taken
  mailbox_word_if #(.W(WORD_W)) mw ();
  logic push_valid_ff, nxt_push_valid;
  logic [WORD_W-1:0] word_ff, nxt_word;

  always_comb begin
    nxt_push_valid = push_valid_ff;
    nxt_word = word_ff;
    if (exch_tick) begin
      nxt_push_valid = 1'b1;
      nxt_word = {tb, sb, fb};
    end else if (push_valid_ff && mw.ready) begin
      nxt_push_valid = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      push_valid_ff <= 1'b0;
      word_ff <= '0;
    end else if (ce_in) begin
      push_valid_ff <= nxt_push_valid;
      word_ff <= nxt_word;
    end
  end

  assign mw.valid = push_valid_ff;
  assign mw.data = word_ff;

  logic [WORD_W-1:0] buf_data;

  status_skid #(.W(WORD_W)) u_skid (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .push(mw),
    .ready_in(mailbox_ready_in),
    .valid_out(status_valid_out),
    .data_out(buf_data)
  );

  assign status_first_out = buf_data[BYTE_W-1:0];
  assign status_second_out = buf_data[2*BYTE_W-1:BYTE_W];
  assign status_third_out = buf_data[WORD_W-1:2*BYTE_W];

  // helper: ce cycles since the last exchange tick, for the rate check
  logic [CNT_W-1:0] gap_ff;
  logic gap_ok_ff;
  logic [MODE_W-1:0] mode_seen_ff;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      gap_ff <= 16'h0000;
      gap_ok_ff <= 1'b0;
      mode_seen_ff <= MODE_OFF;
    end else if (ce_in) begin
      mode_seen_ff <= mode_in;
      gap_ff <= exch_tick ? 16'h0000 : gap_ff + 16'h0001;
      gap_ok_ff <= (mode_seen_ff == mode_in) && (gap_ok_ff || exch_tick) && is_data;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_receive_flag: assert property (push_valid_ff |-> word_ff[FB_RECEIVE])
    else $error("receive flag not set in posted word");
  chk_s1_alternate: assert property (ce_in && baud_strobe_in && s1_present_in |=> s1_phase_ff != $past(s1_phase_ff))
    else $error("s1 phase did not alternate on baud");
  chk_s1_pattern: assert property (exch_tick && is_data |=> ^word_ff[FB_S1_LSB +: 2] == $past(s1_present_in))
    else $error("s1 bits wrong for presence");
  chk_cp_tone: assert property (exch_tick && is_tone |=> word_ff[FB_CP] == !$past(cp_energy_in))
    else $error("call progress bit wrong");
  chk_eq_loss: assert property (exch_tick && (retrain_in || fallback_in) |=> word_ff[BYTE_W + SB_EQ])
    else $error("equalization loss not reported");
  chk_quality_low: assert property (exch_tick |=> word_ff[BYTE_W + SB_QUAL] == $past(quality_low_in))
    else $error("signal quality bit wrong");
  chk_carrier_on: assert property (ce_in && line_level_in > cd_on_th |=> !cd_lost_ff)
    else $error("carrier not detected above threshold");
  chk_carrier_hold: assert property (ce_in && line_level_in <= cd_on_th && line_level_in >= cd_off_th
    |=> $stable(cd_lost_ff) && (cd_on_th - cd_off_th >= CD_HYST_MIN))
    else $error("carrier changed inside hysteresis band");
  chk_descr_data: assert property (ce_in && baud_strobe_in && !descrambler_en_in |=> rx_ff == $past(raw_bits_in))
    else $error("undescrambled data not passed");
  chk_unused_ones: assert property (exch_tick && is_dpsk && low_rate_in |=> &word_ff[2*BYTE_W + 2 +: 3])
    else $error("unused data bits not one");
  chk_exch_rate: assert property (exch_tick && gap_ok_ff |-> gap_ff == CNT_W'(DATA_EXCH_CYCLES - 1))
    else $error("data mode exchange period wrong");
  chk_answer_tone: assert property (exch_tick && is_tone && !tone_1650_sel_in
    |=> word_ff[2*BYTE_W + TB_TONE] == !$past(tone_2100_in))
    else $error("answer tone bit wrong");
  chk_reserved_zero: assert property (push_valid_ff |-> !word_ff[FB_RSV] && !word_ff[2*BYTE_W]
    && word_ff[BYTE_W +: 4] == 4'h0 && !word_ff[2*BYTE_W - 1])
    else $error("reserved bit not zero");

  cov_s1_word: cover property (exch_tick && is_data && s1_present_in);
  cov_tone_hit: cover property (exch_tick && is_tone && tone_1650_sel_in && tone_1650_in);
  cov_fsk_word: cover property (exch_tick && is_fsk);
  cov_stall: cover property (push_valid_ff && !mw.ready);
endmodule

// >>> tb/mailbox_reader.sv
/*
  control processor model: takes receive status words out of the mailbox.
  assumes one clock shared with the word builder; stall_in holds ready low.
*/
`timescale 1ns/1ps
module mailbox_reader (
  // clock
  input wire logic clock_in,
  input wire logic ce_in,
  // control
  input wire logic stall_in,
  // mailbox
  input wire logic valid_in,
  input wire logic [23:0] word_in,
  output logic ready_out,
  // capture
  output logic got_out,
  output logic [23:0] word_out
);
  // ready is a plain level, so a stall of any length is legal for the writer
  assign ready_out = !stall_in;
  always @(posedge clock_in) begin
    got_out <= ce_in && valid_in && ready_out;
    if (ce_in && valid_in && ready_out) begin
      word_out <= word_in;
    end
  end
endmodule

// >>> tb/rx_status_word_tb.sv
/*
  self-checking bench for the receive status word builder.
  assumes the mailbox reader model in tb/ and short exchange periods.
*/
`timescale 1ns/1ps
module rx_status_word_tb;
  import rx_status_pkg::*;
  localparam int unsigned DP = 20;
  localparam int unsigned FP = 10;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce = 1'b1;
  logic [3:0] mode = MODE_OFF;
  logic sel = 1'b0, leased = 1'b0, de = 1'b0, lr = 1'b0, baud = 1'b0, s1 = 1'b0, sstb = 1'b0, sbit = 1'b0;
  logic [3:0] raw = 4'h0, descr = 4'h0;
  logic cp = 1'b0, t21 = 1'b0, t16 = 1'b0, rtr = 1'b0, fb = 1'b0, ql = 1'b0, stall = 1'b0;
  logic signed [7:0] lvl = 8'sh80;
  logic valid, ready, got;
  logic cd = CD_LOST_RST;
  logic [7:0] b1, b2, b3;
  logic [23:0] word, w;
  logic [5:0] smp = 6'h3f;
  logic [1:0] prev;
  logic signed [7:0] lv [10] = '{8'shd8, 8'shd3, 8'shce, 8'shd3, 8'shd5, 8'she2, 8'shdd, 8'shda, 8'shd8, 8'shdd};
  int num_errors = 0, tests_run = 0, cyc = 0, t0 = 0, t1 = 0, n;

  rx_status_word #(.DATA_EXCH_CYCLES(DP), .FSK_EXCH_CYCLES(FP)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
    .ce_in(ce), .mode_in(mode), .tone_1650_sel_in(sel), .leased_line_in(leased), .descrambler_en_in(de),
    .low_rate_in(lr), .baud_strobe_in(baud), .raw_bits_in(raw), .descr_bits_in(descr), .s1_present_in(s1),
    .sample_strobe_in(sstb), .sample_in(sbit), .cp_energy_in(cp), .tone_2100_in(t21), .tone_1650_in(t16),
    .retrain_in(rtr), .fallback_in(fb), .quality_low_in(ql), .line_level_in(lvl), .mailbox_ready_in(ready),
    .status_valid_out(valid), .status_first_out(b1), .status_second_out(b2), .status_third_out(b3));
  mailbox_reader u_rd (.clock_in(clock_in), .ce_in(ce), .stall_in(stall), .valid_in(valid),
    .word_in({b3, b2, b1}), .ready_out(ready), .got_out(got), .word_out(word));

  initial begin
    forever #20 clock_in = ~clock_in;
  end

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under ten thousand cycles
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic take(output logic [23:0] v);
    int k;
    k = 0;
    @(negedge clock_in);
    while (got !== 1'b1 && k < 200) begin
      @(negedge clock_in);
      k++;
    end
    chk("word wait", 24'h0, 24'(k >= 200));
    t0 = t1;
    t1 = cyc;
    v = word;
  endtask

  // the first word after a change may be a snapshot from before it, so drop it
  task automatic fresh();
    take(w);
    take(w);
  endtask

  task automatic strobe_baud();
    @(negedge clock_in) baud = 1'b1;
    @(negedge clock_in) baud = 1'b0;
  endtask

  task automatic set_lvl(input logic signed [7:0] v);
    @(negedge clock_in) lvl = v;
    if (v > (leased ? CD_ON_LEASED : CD_ON_PSTN)) cd = 1'b0;
    else if (v < (leased ? CD_OFF_LEASED : CD_OFF_PSTN)) cd = 1'b1;
  endtask

  function automatic logic [23:0] exp_w(input logic [1:0] s1b);
    logic [3:0] m;
    logic [7:0] f, t;
    m = (mode == MODE_QAM) ? MASK_QAM : (lr ? MASK_DPSK_LO : MASK_DPSK_HI);
    f = 8'h1f;
    t = 8'hfe;
    if (mode == MODE_QAM || mode == MODE_DPSK) begin
      f = {s1b, 1'b0, raw | ~m, 1'b1};
      t = {3'h7, (de ? descr : raw) | ~m, 1'b0};
    end else if (mode >= MODE_FSK_FIRST && mode <= MODE_FSK_LAST) begin
      t = {1'b1, smp, 1'b0};
    end else if (mode == MODE_TONE) begin
      f = {~cp, 7'h1f};
      t = {~(sel ? t16 : t21), 7'h7e};
    end
    return {t, 1'b0, cd, ql, rtr | fb, 4'h0, f};
  endfunction

  initial begin
    void'($urandom(17));
    repeat (20) @(posedge clock_in);
    @(negedge clock_in) rst_in = 1'b0;
    chk("reset word", 24'h0, {b3, b2, b1 | {7'h0, valid}});
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_in);
      mode = i[0] ? MODE_QAM : MODE_DPSK;
      lr = i[1];
      de = i[2];
      raw = (i == 0) ? 4'h0 : 4'($urandom);
      descr = 4'($urandom);
      rtr = i[1] & i[2];
      fb = i[0] & ~i[2];
      ql = i[2];
      strobe_baud();
      fresh();
      chk("data word", exp_w(S1_NONE), w);
    end
    take(w);
    chk("data spacing", 24'(DP), 24'(t1 - t0));
    @(negedge clock_in) s1 = 1'b1;
    strobe_baud();
    fresh();
    for (int k = 0; k < 4; k++) begin
      prev = w[7:6];
      strobe_baud();
      fresh();
      chk("s1 phase", 24'(prev == S1_PHASE_A ? S1_PHASE_B : S1_PHASE_A), 24'(w[7:6]));
    end
    @(negedge clock_in) s1 = 1'b0;
    fresh();
    chk("s1 absent", exp_w(S1_NONE), w);
    for (int k = 0; k < 10; k++) begin
      @(negedge clock_in) leased = (k >= 5);
      set_lvl(lv[k]);
      fresh();
      chk("carrier word", exp_w(S1_NONE), w);
    end
    for (int i = 0; i < 16; i++) begin
      @(negedge clock_in);
      mode = MODE_TONE;
      cp = i[0];
      t21 = i[1];
      t16 = i[2];
      sel = i[3];
      fresh();
      chk("tone word", exp_w(S1_NONE), w);
    end
    take(w);
    chk("tone spacing", 24'(DP), 24'(t1 - t0));
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_in) mode = 4'(MODE_FSK_FIRST + i % 4);
      smp = (i == 0) ? 6'h01 : 6'($urandom);
      for (int j = 0; j < SAMPLES; j++) begin
        @(negedge clock_in) sbit = smp[j];
        sstb = 1'b1;
        @(negedge clock_in) sstb = 1'b0;
      end
      fresh();
      chk("fsk word", exp_w(S1_NONE), w);
    end
    take(w);
    chk("fsk spacing", 24'(FP), 24'(t1 - t0));
    @(negedge clock_in) mode = MODE_QAM;
    stall = 1'b1;
    repeat (5 * DP) @(negedge clock_in);
    stall = 1'b0;
    fresh();
    chk("buffered burst", 24'h1, 24'(t1 - t0 < DP));
    chk("buffered word", exp_w(S1_NONE), w);
    // clock enable low must freeze the exchange: no word may leave while it stays low
    @(negedge clock_in) ce = 1'b0;
    n = 0;
    repeat (3 * DP) begin
      @(negedge clock_in);
      n += int'(got === 1'b1);
    end
    chk("frozen words", 24'h0, 24'(n));
    @(negedge clock_in) ce = 1'b1;
    fresh();
    chk("thawed word", exp_w(S1_NONE), w);
    @(negedge clock_in) mode = MODE_OFF;
    repeat (5) @(negedge clock_in);
    n = 0;
    repeat (3 * DP) begin
      @(negedge clock_in);
      n += int'(got === 1'b1);
    end
    chk("idle words", 24'h0, 24'(n));
    complete_run();
  end
endmodule
